// File: bfr_top.sv
// bidirectional two-fifo block: reset, timing mode, offset setup, mailboxes
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps

module bfr_top import bfr_pkg::*; (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic FIFO1_RESET_N_I,
  input wire logic FIFO2_RESET_N_I,
  input wire logic FLAG_SELECT_0_I,
  input wire logic FLAG_SELECT_1_I,
  input wire logic FALL_THROUGH_SELECT_I,
  input wire logic PORT_A_CLOCK_I,
  input wire logic PORT_A_CHIP_SELECT_N_I,
  input wire logic PORT_A_WRITE_READ_I,
  input wire logic PORT_A_ENABLE_I,
  input wire logic PORT_A_MAIL_SELECT_I,
  input wire logic [DW-1:0] PORT_A_DATA_I,
  output logic [DW-1:0] PORT_A_DATA_O,
  output logic PORT_A_DATA_OE_N_O,
  output logic PORT_A_INPUT_READY_O,
  output logic PORT_A_OUTPUT_READY_O,
  output logic PORT_A_ALMOST_EMPTY_N_O,
  output logic PORT_A_ALMOST_FULL_N_O,
  input wire logic PORT_B_CLOCK_I,
  input wire logic PORT_B_CHIP_SELECT_N_I,
  input wire logic PORT_B_WRITE_READ_I,
  input wire logic PORT_B_ENABLE_I,
  input wire logic PORT_B_MAIL_SELECT_I,
  input wire logic [DW-1:0] PORT_B_DATA_I,
  output logic [DW-1:0] PORT_B_DATA_O,
  output logic PORT_B_DATA_OE_N_O,
  output logic PORT_B_INPUT_READY_O,
  output logic PORT_B_OUTPUT_READY_O,
  output logic PORT_B_ALMOST_EMPTY_N_O,
  output logic PORT_B_ALMOST_FULL_N_O,
  output logic MAIL1_FULL_N_O,
  output logic MAIL2_FULL_N_O,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef struct packed {
    logic [1:0] clk_prev;
    logic [1:0] rst_prev;
    logic [1:0][1:0] fs_cap;
    logic [1:0] mode_std;
    logic [1:0] mode_pend;
    logic [1:0][1:0] ir_cnt;
    logic [1:0][AW-1:0] wptr;
    logic [1:0][AW-1:0] rptr;
    logic [1:0][AW:0] cnt;
    logic [1:0] ir;
    logic [1:0] orf;
    logic [1:0] ae_n;
    logic [1:0] af_n;
    logic [1:0] mbf_n;
    logic [1:0][DW-1:0] dout;
    logic [1:0][DW-1:0] mail;
    logic [1:0][OW-1:0] ox;
    logic [1:0][OW-1:0] oy;
    logic prog_mode;
    logic [2:0] prog_cnt;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bfr_st_t;

  bfr_st_t st_reg;
  bfr_st_t st_next;
  bfr_pins_t pins_raw;
  bfr_pins_t pins;
  logic [DW-1:0] mem [2][2**AW];
  logic [1:0] mem_we;
  logic [1:0] evt;
  logic [1:0] wdir;
  logic [1:0] fwr;
  logic [1:0] mwr;
  logic [1:0] frd;
  logic [1:0] mrd;
  logic [1:0] rst_rise;

  function automatic bfr_reg_t reg_idx(input logic [ADDR_W-1:0] a);
    case (a)
      REG_STATUS: reg_idx = RI_STATUS;
      REG_Y1: reg_idx = RI_Y1;
      REG_X1: reg_idx = RI_X1;
      REG_Y2: reg_idx = RI_Y2;
      REG_X2: reg_idx = RI_X2;
      default: reg_idx = RI_NONE;
    endcase
  endfunction

  function automatic logic [OW-1:0] off_val(input bfr_st_t s, input bfr_reg_t i);
    case (i)
      RI_Y1: off_val = s.oy[0];
      RI_X1: off_val = s.ox[0];
      RI_Y2: off_val = s.oy[1];
      RI_X2: off_val = s.ox[1];
      default: off_val = '0;
    endcase
  endfunction

  function automatic bfr_st_t off_put(input bfr_st_t s, input bfr_reg_t i,
                                      input logic [OW-1:0] v);
    bfr_st_t t;
    t = s;
    case (i)
      RI_Y1: t.oy[0] = v;
      RI_X1: t.ox[0] = v;
      RI_Y2: t.oy[1] = v;
      RI_X2: t.ox[1] = v;
      default: t = s;
    endcase
    return t;
  endfunction

  assign pins_raw.rst_n = {FIFO2_RESET_N_I, FIFO1_RESET_N_I};
  assign pins_raw.fs = {FLAG_SELECT_1_I, FLAG_SELECT_0_I};
  assign pins_raw.fall_through_select = FALL_THROUGH_SELECT_I;
  assign pins_raw.port[0] = {PORT_A_CLOCK_I, PORT_A_CHIP_SELECT_N_I, PORT_A_WRITE_READ_I,
                             PORT_A_ENABLE_I, PORT_A_MAIL_SELECT_I, PORT_A_DATA_I};
  assign pins_raw.port[1] = {PORT_B_CLOCK_I, PORT_B_CHIP_SELECT_N_I, PORT_B_WRITE_READ_I,
                             PORT_B_ENABLE_I, PORT_B_MAIL_SELECT_I, PORT_B_DATA_I};

  // every fifo-side pin, fifo resets included, crosses two flops before any decode; the bus slave pins are used directly
  bfr_sync #(.W($bits(bfr_pins_t))) u_pin_sync (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .d_i(pins_raw),
    .q_o(pins)
  );

  // port b direction pin is inverted with respect to port a
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      evt[p] = pins.port[p].clk & ~st_reg.clk_prev[p];
      wdir[p] = (p == 0) ? pins.port[p].wr : ~pins.port[p].wr;
      fwr[p] = evt[p] & ~pins.port[p].cs_n & wdir[p] & pins.port[p].en & ~pins.port[p].mb;
      mwr[p] = evt[p] & ~pins.port[p].cs_n & wdir[p] & pins.port[p].en & pins.port[p].mb;
      frd[p] = evt[p] & ~pins.port[p].cs_n & ~wdir[p] & pins.port[p].en & ~pins.port[p].mb;
      mrd[p] = evt[p] & ~pins.port[p].cs_n & ~wdir[p] & pins.port[p].en & pins.port[p].mb;
      rst_rise[p] = pins.rst_n[p] & ~st_reg.rst_prev[p];
    end
  end

  always_comb begin
    logic [AW:0] cnt_new;
    logic busy;
    int r;
    bfr_reg_t idx;
    logic [OW-1:0] v;
    cnt_new = '0;
    busy = 1'b0;
    r = 0;
    idx = RI_NONE;
    v = '0;
    st_next = st_reg;
    mem_we = '0;
    st_next.clk_prev = {pins.port[1].clk, pins.port[0].clk};
    st_next.rst_prev = pins.rst_n;

    // bus slave: address and data taken in either order, response after both
    if (S_AXI_AWVALID && !st_reg.aw_got) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st_reg.w_got) begin
      st_next.w_got = 1'b1;
      st_next.wdata = S_AXI_WDATA;
      st_next.wstrb = S_AXI_WSTRB;
    end
    if (st_reg.bvalid && S_AXI_BREADY) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      idx = reg_idx(st_reg.awaddr);
      v = off_val(st_reg, idx);
      if (st_reg.wstrb[0]) begin
        v[LANE-1:0] = st_reg.wdata[LANE-1:0];
      end
      if (st_reg.wstrb[1]) begin
        v[OW-1:LANE] = st_reg.wdata[OW-1:LANE];
      end
      // status is read-only and unmapped words are refused
      st_next = off_put(st_next, idx, v);
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = (idx == RI_STATUS || idx == RI_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_reg.rvalid && S_AXI_RREADY) begin
      st_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !st_reg.rvalid) begin
      idx = reg_idx(S_AXI_ARADDR);
      st_next.rvalid = 1'b1;
      st_next.rresp = (idx == RI_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (idx == RI_STATUS) begin
        st_next.rdata = {STATUS_PAD, st_reg.prog_cnt, st_reg.prog_mode, st_reg.mbf_n,
                         st_reg.ae_n, st_reg.af_n, st_reg.orf, st_reg.ir, st_reg.mode_std};
      end else begin
        st_next.rdata = {{(32 - OW){1'b0}}, off_val(st_reg, idx)};
      end
    end

    // mail reads clear first so a same-edge mail write keeps its flag low
    for (int p = 0; p < 2; p++) begin
      if (mrd[p]) begin
        st_next.mbf_n[1 - p] = 1'b1;
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (mwr[p]) begin
        st_next.mail[p] = pins.port[p].data;
        st_next.mbf_n[p] = 1'b0;
      end
    end

    for (int f = 0; f < 2; f++) begin
      r = 1 - f;
      cnt_new = st_reg.cnt[f];
      if (rst_rise[f]) begin
        st_next.fs_cap[f] = pins.fs;
        case (pins.fs)
          FS_HH: st_next = off_put(st_next, bfr_reg_t'(RI_Y1 + 2 * f), PRESET_HH);
          FS_HL: st_next = off_put(st_next, bfr_reg_t'(RI_Y1 + 2 * f), PRESET_HL);
          FS_LH: st_next = off_put(st_next, bfr_reg_t'(RI_Y1 + 2 * f), PRESET_LH);
          default: st_next = st_next;
        endcase
        case (pins.fs)
          FS_HH: st_next = off_put(st_next, bfr_reg_t'(RI_X1 + 2 * f), PRESET_HH);
          FS_HL: st_next = off_put(st_next, bfr_reg_t'(RI_X1 + 2 * f), PRESET_HL);
          FS_LH: st_next = off_put(st_next, bfr_reg_t'(RI_X1 + 2 * f), PRESET_LH);
          default: st_next = st_next;
        endcase
        if (f == 0) begin
          // port programming is chosen by the fifo1 edge of a master reset
          st_next.prog_mode = (pins.fs == FS_PORT);
          st_next.prog_cnt = '0;
        end
      end
      // writer side: fifo f is written from port f
      if (evt[f]) begin
        if (st_reg.mode_pend[f]) begin
          st_next.mode_pend[f] = 1'b0;
          st_next.mode_std[f] = pins.fall_through_select;
        end
        if (st_reg.ir_cnt[f] != IR_WAIT) begin
          st_next.ir_cnt[f] = st_reg.ir_cnt[f] + 2'h1;
        end
        if (fwr[f] && st_reg.ir[f]) begin
          if (f == 0 && st_next.prog_mode && st_next.prog_cnt != PROG_WORDS) begin
            idx = bfr_reg_t'(st_next.prog_cnt + PROG_STEP);
            st_next = off_put(st_next, idx, pins.port[f].data[OW-1:0]);
            st_next.prog_cnt = st_next.prog_cnt + PROG_STEP;
          end else begin
            mem_we[f] = 1'b1;
            st_next.wptr[f] = st_reg.wptr[f] + 1'b1;
            cnt_new = cnt_new + 1'b1;
          end
        end
      end
      // reader side: fifo f is read from the opposite port
      if (evt[r]) begin
        if (st_reg.mode_std[f]) begin
          if (frd[r] && st_reg.orf[f]) begin
            st_next.dout[f] = mem[f][st_reg.rptr[f]];
            st_next.rptr[f] = st_reg.rptr[f] + 1'b1;
            cnt_new = cnt_new - 1'b1;
          end
          st_next.orf[f] = (cnt_new != CNT_ZERO);
        end else if ((frd[r] && st_reg.orf[f]) || !st_reg.orf[f]) begin
          // an empty output stage pulls the next word in without a read; a word written
          // on this same edge is not in memory yet, so it waits for the next reader edge
          if (st_reg.cnt[f] != CNT_ZERO) begin
            st_next.dout[f] = mem[f][st_reg.rptr[f]];
            st_next.rptr[f] = st_reg.rptr[f] + 1'b1;
            cnt_new = cnt_new - 1'b1;
            st_next.orf[f] = 1'b1;
          end else begin
            st_next.orf[f] = 1'b0;
          end
        end
        st_next.ae_n[f] = (cnt_new > {1'b0, st_next.ox[f]});
      end
      if (evt[f]) begin
        busy = (f == 1) && st_next.prog_mode && (st_next.prog_cnt != PROG_WORDS);
        st_next.ir[f] = (st_next.ir_cnt[f] == IR_WAIT) && !busy && (cnt_new < DEPTH_CNT);
        st_next.af_n[f] = (cnt_new < (DEPTH_CNT - {1'b0, st_next.oy[f]}));
      end
      st_next.cnt[f] = cnt_new;
      // reset level wins over everything on this fifo, with no port edge needed
      if (!pins.rst_n[f]) begin
        st_next.wptr[f] = '0;
        st_next.rptr[f] = '0;
        st_next.cnt[f] = '0;
        st_next.ir[f] = 1'b0;
        st_next.orf[f] = 1'b0;
        st_next.ir_cnt[f] = '0;
        st_next.mode_pend[f] = 1'b1;
        st_next.ae_n[f] = 1'b0;
        st_next.af_n[f] = 1'b1;
        st_next.mbf_n[f] = 1'b1;
        mem_we[f] = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_reg <= '0;
      st_reg.af_n <= '1;
      st_reg.mbf_n <= '1;
      st_reg.mode_pend <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage is not reset; the pointers define what is valid
  always_ff @(posedge MCLK_I) begin
    for (int f = 0; f < 2; f++) begin
      if (mem_we[f]) begin
        mem[f][st_reg.wptr[f]] <= pins.port[f].data;
      end
    end
  end

  assign PORT_A_DATA_O = pins.port[0].mb ? st_reg.mail[1] : st_reg.dout[1];
  assign PORT_B_DATA_O = pins.port[1].mb ? st_reg.mail[0] : st_reg.dout[0];
  assign PORT_A_DATA_OE_N_O = pins.port[0].cs_n | pins.port[0].wr;
  assign PORT_B_DATA_OE_N_O = pins.port[1].cs_n | ~pins.port[1].wr;
  assign PORT_A_INPUT_READY_O = st_reg.ir[0];
  assign PORT_B_INPUT_READY_O = st_reg.ir[1];
  assign PORT_A_OUTPUT_READY_O = st_reg.orf[1];
  assign PORT_B_OUTPUT_READY_O = st_reg.orf[0];
  assign PORT_A_ALMOST_EMPTY_N_O = st_reg.ae_n[1];
  assign PORT_B_ALMOST_EMPTY_N_O = st_reg.ae_n[0];
  assign PORT_A_ALMOST_FULL_N_O = st_reg.af_n[0];
  assign PORT_B_ALMOST_FULL_N_O = st_reg.af_n[1];
  assign MAIL1_FULL_N_O = st_reg.mbf_n[0];
  assign MAIL2_FULL_N_O = st_reg.mbf_n[1];
  assign S_AXI_AWREADY = !st_reg.aw_got;
  assign S_AXI_WREADY = !st_reg.w_got;
  assign S_AXI_BVALID = st_reg.bvalid;
  assign S_AXI_BRESP = st_reg.bresp;
  assign S_AXI_ARREADY = !st_reg.rvalid;
  assign S_AXI_RVALID = st_reg.rvalid;
  assign S_AXI_RDATA = st_reg.rdata;
  assign S_AXI_RRESP = st_reg.rresp;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  a_reset_flag_set: assert property (!pins.rst_n[0] |=>
    !st_reg.ir[0] && !st_reg.orf[0] && !PORT_B_ALMOST_EMPTY_N_O && PORT_A_ALMOST_FULL_N_O)
    else $error("fifo1 reset did not force its flags");
  a_reset_mail_flag: assert property (!pins.rst_n[1] |=> MAIL2_FULL_N_O)
    else $error("fifo2 reset left mail2 flag low");
  a_ready_two_edges: assert property ($rose(st_reg.ir[0]) |->
    $past(evt[0]) && st_reg.ir_cnt[0] == IR_WAIT && $past(st_reg.ir_cnt[0]) != 2'h0)
    else $error("input ready rose before two writer edges");
  a_select_capture: assert property (rst_rise[1] |=> st_reg.fs_cap[1] == $past(pins.fs))
    else $error("flag selects not captured at fifo2 reset edge");
  a_mode_sample_edge: assert property (pins.rst_n[0] && st_reg.mode_pend[0] && evt[0]
    |=> !st_reg.mode_pend[0] && st_reg.mode_std[0] == $past(pins.fall_through_select))
    else $error("timing mode not sampled on first port a edge");
  a_preset_sixty_four: assert property (rst_rise[0] && pins.fs == FS_HH
    |=> st_reg.ox[0] == PRESET_HH && st_reg.oy[0] == PRESET_HH)
    else $error("fifo1 offsets not preset to 64");
  a_fall_through_first: assert property (pins.rst_n[0] && !st_reg.mode_std[0] &&
    !st_reg.orf[0] && st_reg.cnt[0] != CNT_ZERO && evt[1] |=> PORT_B_OUTPUT_READY_O)
    else $error("first word did not fall through to port b");
  a_standard_hold: assert property (pins.rst_n[0] && st_reg.mode_std[0] &&
    !(frd[1] && st_reg.orf[0]) |=> $stable(st_reg.dout[0]))
    else $error("standard mode output changed without a read");
  a_mail_write_show: assert property (mwr[0] && pins.rst_n[0] && !pins.port[1].cs_n
    ##1 pins.port[1].mb |-> PORT_B_DATA_O == $past(pins.port[0].data) && !MAIL1_FULL_N_O)
    else $error("mail1 write not visible on port b");
  a_mail_read_flag: assert property (mrd[0] && !mwr[1] |=> MAIL2_FULL_N_O)
    else $error("mail2 read did not set its flag");
  a_program_first: assert property (pins.rst_n[0] && st_reg.prog_mode &&
    st_reg.prog_cnt == 3'h0 && fwr[0] && st_reg.ir[0]
    |=> st_reg.oy[0] == $past(pins.port[0].data[OW-1:0]) && st_reg.cnt[0] == CNT_ZERO)
    else $error("first programming write did not load y1");

  c_fall_through: cover property (!st_reg.mode_std[0] && $rose(st_reg.orf[0]));
  c_program_done: cover property (st_reg.prog_mode && st_reg.prog_cnt == PROG_WORDS);
  c_mail_swap: cover property (mwr[0] ##[1:40] mrd[1]);
  c_std_read: cover property (st_reg.mode_std[1] && frd[0] && st_reg.orf[1]);
endmodule // bfr_top

// File: bfr_sync.sv
// shared constants of the bidirectional fifo block and its pin synchroniser
`timescale 1ns/100ps

package bfr_pkg;
  localparam int DW = 36;
  localparam int AW = 13;
  localparam int OW = 13;
  localparam int ADDR_W = 8;
  localparam int LANE = 8;
  localparam logic [AW:0] DEPTH_CNT = 14'h2000;
  localparam logic [AW:0] CNT_ZERO = 14'h0000;
  // offset presets chosen by {flag_select_1, flag_select_0} at reset release
  localparam logic [1:0] FS_HH = 2'h3;
  localparam logic [1:0] FS_HL = 2'h2;
  localparam logic [1:0] FS_LH = 2'h1;
  localparam logic [1:0] FS_PORT = 2'h0;
  localparam logic [OW-1:0] PRESET_HH = 13'h0040;
  localparam logic [OW-1:0] PRESET_HL = 13'h0010;
  localparam logic [OW-1:0] PRESET_LH = 13'h0008;
  localparam logic [1:0] IR_WAIT = 2'h2;
  localparam logic [2:0] PROG_WORDS = 3'h4;
  localparam logic [2:0] PROG_STEP = 3'h1;
  // register map of the bus slave
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_Y1 = 8'h04;
  localparam logic [ADDR_W-1:0] REG_X1 = 8'h08;
  localparam logic [ADDR_W-1:0] REG_Y2 = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_X2 = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] STATUS_PAD = 16'h0000;

  typedef enum logic [2:0] {
    RI_STATUS = 3'h0,
    RI_Y1 = 3'h1,
    RI_X1 = 3'h2,
    RI_Y2 = 3'h3,
    RI_X2 = 3'h4,
    RI_NONE = 3'h7
  } bfr_reg_t;

  typedef struct packed {
    logic clk;
    logic cs_n;
    logic wr;
    logic en;
    logic mb;
    logic [DW-1:0] data;
  } bfr_port_t;

  // index 0 is fifo1 / port a, index 1 is fifo2 / port b
  typedef struct packed {
    logic [1:0] rst_n;
    logic [1:0] fs;
    logic fall_through_select;
    bfr_port_t [1:0] port;
  } bfr_pins_t;
endpackage

module bfr_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bfr_sync_st_t;

  bfr_sync_st_t st_reg;
  bfr_sync_st_t st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule // bfr_sync

// File: bfr_port_agent.sv
// behavioural processor on one fifo port: clocks one port operation per call
`timescale 1ns/100ps

module bfr_port_agent import bfr_pkg::*; (
  input wire logic mclk_i,
  output logic clk_o,
  output logic cs_n_o,
  output logic wr_o,
  output logic en_o,
  output logic mb_o,
  output logic [DW-1:0] data_o
);
  initial begin
    {clk_o, cs_n_o, wr_o, en_o, mb_o} = 5'h08;
    data_o = '0;
  end
  // levels last 4 mclk so the synchronised edge detector never misses one
  task automatic op(input logic c, w, e, m, input logic [DW-1:0] d);
    @(posedge mclk_i);
    {cs_n_o, wr_o, en_o, mb_o} <= {c, w, e, m};
    data_o <= d;
    repeat (2) @(posedge mclk_i);
    clk_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    clk_o <= 1'b0;
    en_o <= 1'b0;
    // hold time over: the bus no longer shows the old word
    data_o <= ~d;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule // bfr_port_agent

// File: bfr_top_tb_top.sv
// self-checking bench: fifo resets, presets, mailboxes, fall-through, offset loading
`timescale 1ns/100ps

module bfr_top_tb_top import bfr_pkg::*;;
  logic MCLK_I, RST_B_I, FIFO1_RESET_N_I, FIFO2_RESET_N_I, FLAG_SELECT_0_I, FLAG_SELECT_1_I;
  logic FALL_THROUGH_SELECT_I, PORT_A_CLOCK_I, PORT_A_CHIP_SELECT_N_I, PORT_A_WRITE_READ_I;
  logic PORT_A_ENABLE_I, PORT_A_MAIL_SELECT_I, PORT_B_CLOCK_I, PORT_B_CHIP_SELECT_N_I;
  logic PORT_B_WRITE_READ_I, PORT_B_ENABLE_I, PORT_B_MAIL_SELECT_I;
  logic [DW-1:0] PORT_A_DATA_I, PORT_A_DATA_O, PORT_B_DATA_I, PORT_B_DATA_O;
  logic PORT_A_DATA_OE_N_O, PORT_A_INPUT_READY_O, PORT_A_OUTPUT_READY_O;
  logic PORT_A_ALMOST_EMPTY_N_O, PORT_A_ALMOST_FULL_N_O, PORT_B_DATA_OE_N_O;
  logic PORT_B_INPUT_READY_O, PORT_B_OUTPUT_READY_O, PORT_B_ALMOST_EMPTY_N_O;
  logic PORT_B_ALMOST_FULL_N_O, MAIL1_FULL_N_O, MAIL2_FULL_N_O;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [12:0] ev;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  wire logic [9:0] flags = {PORT_A_INPUT_READY_O, PORT_B_INPUT_READY_O, PORT_A_OUTPUT_READY_O,
    PORT_B_OUTPUT_READY_O, PORT_A_ALMOST_EMPTY_N_O, PORT_B_ALMOST_EMPTY_N_O,
    PORT_A_ALMOST_FULL_N_O, PORT_B_ALMOST_FULL_N_O, MAIL1_FULL_N_O, MAIL2_FULL_N_O};

  bfr_top i_bfr_top (.*);
  bfr_port_agent i_bfr_port_agent_a (.mclk_i(MCLK_I), .clk_o(PORT_A_CLOCK_I),
    .cs_n_o(PORT_A_CHIP_SELECT_N_I), .wr_o(PORT_A_WRITE_READ_I), .en_o(PORT_A_ENABLE_I),
    .mb_o(PORT_A_MAIL_SELECT_I), .data_o(PORT_A_DATA_I));
  bfr_port_agent i_bfr_port_agent_b (.mclk_i(MCLK_I), .clk_o(PORT_B_CLOCK_I),
    .cs_n_o(PORT_B_CHIP_SELECT_N_I), .wr_o(PORT_B_WRITE_READ_I), .en_o(PORT_B_ENABLE_I),
    .mb_o(PORT_B_MAIL_SELECT_I), .data_o(PORT_B_DATA_I));

  initial begin
    MCLK_I = 1'b0;
    forever #25 MCLK_I = ~MCLK_I;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc >= 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [35:0] e, s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge MCLK_I);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    while (!(aw && w)) begin
      @(posedge MCLK_I);
      if (S_AXI_AWVALID && S_AXI_AWREADY === 1'b1) begin aw = 1'b1; S_AXI_AWVALID <= 1'b0; end
      if (S_AXI_WVALID && S_AXI_WREADY === 1'b1) begin w = 1'b1; S_AXI_WVALID <= 1'b0; end
    end
    while (S_AXI_BVALID !== 1'b1) @(posedge MCLK_I);
    rsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge MCLK_I);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(posedge MCLK_I); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    while (S_AXI_RVALID !== 1'b1) @(posedge MCLK_I);
    {rd, rsp} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 1'b0;
  endtask

  // both fifos reset together, select levels held across the rising edge
  task automatic freset(input logic [1:0] fs, input logic ft);
    {FLAG_SELECT_1_I, FLAG_SELECT_0_I, FALL_THROUGH_SELECT_I} <= {fs, ft};
    {FIFO1_RESET_N_I, FIFO2_RESET_N_I} <= 2'h0;
    fork
      repeat (5) i_bfr_port_agent_a.op(1, 0, 0, 0, '0);
      repeat (5) i_bfr_port_agent_b.op(1, 0, 0, 0, '0);
    join
    chk("reset flags", 10'h00F, flags);
    @(posedge MCLK_I);
    {FIFO1_RESET_N_I, FIFO2_RESET_N_I} <= 2'h3;
    repeat (4) @(posedge MCLK_I);
    fork i_bfr_port_agent_a.op(1, 0, 0, 0, '0); i_bfr_port_agent_b.op(1, 0, 0, 0, '0); join
    chk("ir a early", 0, PORT_A_INPUT_READY_O);
    fork i_bfr_port_agent_a.op(1, 0, 0, 0, '0); i_bfr_port_agent_b.op(1, 0, 0, 0, '0); join
    chk("ir a", 1, PORT_A_INPUT_READY_O);
    chk("ir b", fs != 2'h0, PORT_B_INPUT_READY_O);
  endtask

  initial begin
    {RST_B_I, FIFO1_RESET_N_I, FIFO2_RESET_N_I, FLAG_SELECT_0_I, FLAG_SELECT_1_I} = 5'h06;
    {FALL_THROUGH_SELECT_I, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 4'h8;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
    {S_AXI_WDATA, S_AXI_WSTRB} = {32'h0, 4'hF};
    repeat (20) @(posedge MCLK_I);
    RST_B_I <= 1'b1;
    for (int k = 3; k > 0; k--) begin
      freset(2'(k), 1'b1);
      ev = (k == 3) ? PRESET_HH : (k == 2) ? PRESET_HL : PRESET_LH;
      axi_rd(REG_Y1);
      chk("y1 preset", {19'h0, ev}, rd);
      axi_rd(REG_X2);
      chk("x2 preset", {19'h0, ev}, rd);
    end
    // port b already shows its mail register while port a writes it
    i_bfr_port_agent_b.op(0, 1, 0, 1, '0);
    i_bfr_port_agent_a.op(0, 1, 1, 1, 36'h9_8765_4321);
    chk("mail1 flag", 0, MAIL1_FULL_N_O);
    chk("b mail data", 36'h9_8765_4321, PORT_B_DATA_O);
    chk("b oe", 0, PORT_B_DATA_OE_N_O);
    i_bfr_port_agent_b.op(0, 0, 1, 1, 36'h1_2345_6789);
    chk("mail2 flag", 0, MAIL2_FULL_N_O);
    chk("b oe off", 1, PORT_B_DATA_OE_N_O);
    i_bfr_port_agent_a.op(0, 0, 1, 1, '0);
    chk("a mail data", 36'h1_2345_6789, PORT_A_DATA_O);
    chk("mail2 read", 1, MAIL2_FULL_N_O);
    chk("a oe", 0, PORT_A_DATA_OE_N_O);
    i_bfr_port_agent_a.op(0, 1, 0, 0, '0);
    chk("a oe off", 1, PORT_A_DATA_OE_N_O);
    // mail1 still unread here, so the next reset must clear its flag
    freset(2'h3, 1'b0);
    i_bfr_port_agent_a.op(0, 1, 1, 0, 36'hA_5A5A_0F0F);
    i_bfr_port_agent_b.op(0, 1, 0, 0, '0);
    chk("fall_through_select ready", 1, PORT_B_OUTPUT_READY_O);
    chk("fall_through_select data", 36'hA_5A5A_0F0F, PORT_B_DATA_O);
    freset(2'h0, 1'b1);
    for (int i = 0; i < 4; i++) i_bfr_port_agent_a.op(0, 1, 1, 0, 36'(100 * (i + 1)));
    i_bfr_port_agent_a.op(0, 1, 1, 0, 36'h3_C3C3_C3C3);
    i_bfr_port_agent_b.op(1, 0, 0, 0, '0);
    chk("ir b loaded", 1, PORT_B_INPUT_READY_O);
    // standard mode: the stored word waits for an explicit read
    chk("std ready", 1, PORT_B_OUTPUT_READY_O);
    chk("std no fall", 36'hA_5A5A_0F0F, PORT_B_DATA_O);
    i_bfr_port_agent_b.op(0, 1, 1, 0, '0);
    chk("std data", 36'h3_C3C3_C3C3, PORT_B_DATA_O);
    chk("std empty", 0, PORT_B_OUTPUT_READY_O);
    for (int i = 0; i < 4; i++) begin
      axi_rd(REG_Y1 + 8'(4 * i));
      chk("offset load", 32'(100 * (i + 1)), rd);
    end
    axi_rd(REG_STATUS);
    chk("status", {PROG_WORDS, 1'b1, 2'h3}, {rd[15:12], rd[1:0]});
    axi_wr(REG_Y1, 32'h0000_0123);
    chk("wr resp", RESP_OKAY, rsp);
    axi_rd(REG_Y1);
    chk("y1 rw", 32'h0000_0123, rd);
    axi_wr(8'h40, 32'h0000_0001);
    chk("unmapped wr", RESP_SLVERR, rsp);
    axi_rd(8'h40);
    chk("unmapped rd", RESP_SLVERR, rsp);
    wrap_up();
  end
endmodule // bfr_top_tb_top
